// *** logic/mtp_pkg.sv ***
package mtp_pkg;

  // Control register bit positions
  localparam int unsigned C2_OUT_SEL = 3;
  localparam int unsigned C3_AUTOSTOP = 3;
  localparam int unsigned C3_RUN = 2;
  localparam int unsigned C4_PIN_EN = 3;
  localparam int unsigned C4_HI_EXT = 2;
  localparam int unsigned C4_RUN = 1;
  localparam int unsigned C4_SRC = 0;
  localparam int unsigned C2_RUN = 2;
  localparam int unsigned C5_RUN = 2;
  localparam int unsigned C6_LC_RUN = 3;
  localparam int unsigned C6_LC_SRC = 2;
  localparam int unsigned C6_AUTO_GATE = 1;
  localparam int unsigned C6_PIN0_EN = 0;

  // Values after reset
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] CNT8_RST = 8'h00;
  localparam logic [3:0] CNT4_RST = 4'h0;
  localparam logic [15:0] CNT5_RST = 16'hFFFF;

  // Fifth timer underflow masks: 8192, 16384, 32768 counts, full wrap for code 11
  localparam logic [15:0] LEN_MASK0 = 16'h1FFF;
  localparam logic [15:0] LEN_MASK1 = 16'h3FFF;
  localparam logic [15:0] LEN_MASK2 = 16'h7FFF;
  localparam logic [15:0] LEN_MASK3 = 16'hFFFF;

  // Count source codes
  localparam logic [1:0] SRC3_PWM = 2'b00;
  localparam logic [1:0] SRC3_PRESC = 2'b01;
  localparam logic [1:0] SRC3_SECOND_TIMER_UNDERFLOW = 2'b10;
  localparam logic [1:0] SRC3_PIN = 2'b11;
  localparam logic [1:0] SRC2_MAIN = 2'b00;
  localparam logic [1:0] SRC2_PRESC = 2'b01;
  localparam logic [1:0] SRC2_T1UDF = 2'b10;
  localparam logic [1:0] SRC2_PWM = 2'b11;

  typedef enum logic [3:0] {
    OP_NONE, OP_LD_SECOND, OP_LD_THIRD_BOTH, OP_WR_THIRD_RELOAD, OP_LD_FOURTH_LOW,
    OP_WR_HIGH_RELOAD, OP_RESTORE_FOURTH, OP_LD_LCD, OP_WR_CTRL2, OP_WR_CTRL3,
    OP_WR_CTRL4, OP_WR_CTRL5, OP_WR_CTRL6
  } mtp_op_t;

  typedef struct packed {
    mtp_op_t op;
    logic [7:0] data;
  } mtp_cmd_t;

  typedef enum logic {PH_LOW, PH_HIGH} mtp_phase_t;

  typedef struct packed {
    logic [3:0] c2, c3, c4, c5, c6;
    logic [7:0] second_reload, cnt2, third_reload, cnt3;
    logic [7:0] pwm_low_reload, pwm_high_reload, cnt4;
    logic [3:0] lcd_timer_reload, cntlc;
    logic [15:0] cnt5;
    logic [3:0] flags;
    logic sync3, pwm, pwm_prev, run4, pre_div, gate, pin0_out, lcd_clk, wake;
    mtp_phase_t phase;
    logic [2:0] sub_sync, pin1_sync;
    logic sub_lvl, pin1_lvl;
    logic [7:0] per_cnt, per, hold;
    logic pin1_o, pin0_oe, pin1_oe;
  } mtp_state_t;

endpackage

// *** logic/mtp_timer_unit.sv ***
`timescale 1ns/1ps
//Contract
// RL1: Software loads counter, picks source, then sets run bit of second/third timer.
// RL2: An 8-bit timer with reload n divides its count source by n+1.
// RL3: Count pulse at zero is underflow: set flag, reload, keep counting.
// RL4: Second timer underflow halved drives first counter pin when both enables set.
// RL5: Third timer: load counter and reload, write reload only, read counter.
// RL6: Software stops a timer before direct counter access; avoids reload at underflow.
// RL7: Start sync enabled by pin-control bit; valid interrupt edge gates count source.
// RL8: Sync clears on select cleared, reset, or underflow when auto-stop chosen.
// RL9: Fourth timer: load counter+low reload, write high reload, restore, read.
// RL10: Software loads fourth timer, picks source bit 0, then sets run bit 1.
// RL11: With bit 3 set, fourth timer alternates low/high reload every underflow.
// RL12: Fourth timer makes PWM on second counter pin, low/high from reloads.
// RL13: With bit 2 set, high phase stretched half a source period.
// RL14: With extension on, software keeps high reload at one or more.
// RL15: Pin-control bit 1 toggles PWM enable each third underflow unless third stopped.
// RL16: Run bit cleared in high phase: counting continues to next underflow.
// RL17: Fifth timer: 16-bit sub-clock down counter, length bits, run bit, flag.
// RL18: Clearing fifth run bit stops it and sets count to all ones.
// RL19: Fifth timer underflow during power-down wakes the system.
// RL20: LCD timer: 4-bit auto-reload, write-only, source bit 2, run bit 3.
// RL21: LCD timer underflow halved is LCD clock; fifth timer bit 4 a source.
// RL22: Pin sources count rising edges; second pin input forces port output off.
// RL23: Flags set at underflow; cleared on interrupt taken or skip.
// RL24: Fifth length codes give 8192, 16384, 32768 counts.
// RL25: Third source codes: PWM, prescaler, second underflow, second pin.
// RL26: Fourth source: main oscillator, or prescaler output halved.
// RL27: LCD source: fifth timer bit 4, or prescaler output.
module mtp_timer_unit
  import mtp_pkg::*;
(
  input wire logic clk, // 250 MHz core clock
  input wire logic rst_b, // Synchronous reset, active low
  input wire mtp_cmd_t cmd, // One instruction per cycle
  input wire logic [3:0] flag_clr, // Flags 2..5: interrupt taken or skip done
  input wire logic third_sync_select_bit, // Start sync select for third timer
  input wire logic ext_irq_pin_one_edge, // Valid edge pulse from interrupt logic
  input wire logic prescaler_output, // Prescaler underflow pulse
  input wire logic main_osc_tick, // Main oscillator count pulse
  input wire logic first_timer_underflow, // First timer underflow pulse
  input wire logic subclock_input, // Sub-clock pin, asynchronous
  input wire logic counter_pin_one_in, // Second counter pin level, asynchronous
  input wire logic power_down, // Clock-operating power-down active
  output logic [3:0] irq_flags, // Flags for second..fifth timers
  output logic [7:0] third_count, // Third timer counter read
  output logic [7:0] fourth_count, // Fourth timer counter read
  output logic [19:0] ctrl_read, // Control registers 6..2 read back
  output logic counter_pin_zero_o, // First counter pin output level
  output logic counter_pin_zero_oe, // First counter pin driven
  output logic counter_pin_one_o, // Second counter pin output level
  output logic counter_pin_one_oe, // Second counter pin driven
  output logic lcd_clock, // LCD clock
  output logic wake_pulse // Power-down return request
);

  mtp_state_t s_q, s_d;

  // Returns {underflow, next count}
  function automatic logic [8:0] step8(input logic [7:0] c, input logic [7:0] r);
    if (c == 8'h00) begin
      step8 = {1'b1, r}; // see RL3
    end else begin
      step8 = {1'b0, c - 8'h01}; // see RL2
    end
  endfunction

  logic [8:0] r2, r3, r4;
  logic [15:0] len_mask;
  logic tick2, tick3, tick4, ticklc, tick5, t5b4, pin1_rise, sub_rise;
  logic udf2, udf3, udf4, udflc, udf5, run3, go4;
  logic [3:0] udf_all;
  logic [7:0] next_reload4;

  always_comb begin
    s_d = s_q;
    r2 = 9'h000;
    r3 = 9'h000;
    r4 = 9'h000;
    next_reload4 = 8'h00;
    udf2 = 1'b0;
    udf3 = 1'b0;
    udf4 = 1'b0;
    udflc = 1'b0;
    udf5 = 1'b0;
    // Pin synchronisers: stable once second and third flops agree
    s_d.sub_sync = {s_q.sub_sync[1:0], subclock_input};
    s_d.pin1_sync = {s_q.pin1_sync[1:0], counter_pin_one_in};
    sub_rise = (s_q.sub_sync[1] == s_q.sub_sync[2]) && s_q.sub_sync[2] && !s_q.sub_lvl;
    pin1_rise = (s_q.pin1_sync[1] == s_q.pin1_sync[2]) && s_q.pin1_sync[2] && !s_q.pin1_lvl;
    if (s_q.sub_sync[1] == s_q.sub_sync[2]) begin
      s_d.sub_lvl = s_q.sub_sync[2];
    end
    if (s_q.pin1_sync[1] == s_q.pin1_sync[2]) begin
      s_d.pin1_lvl = s_q.pin1_sync[2]; // see RL22
    end
    s_d.pwm_prev = s_q.pwm;
    if (prescaler_output) begin
      s_d.pre_div = !s_q.pre_div;
    end

    // Second timer
    case (s_q.c2[1:0])
      SRC2_MAIN: tick2 = main_osc_tick;
      SRC2_PRESC: tick2 = prescaler_output;
      SRC2_T1UDF: tick2 = first_timer_underflow;
      default: tick2 = s_q.pwm && !s_q.pwm_prev;
    endcase
    if (s_q.c2[C2_RUN] && tick2) begin
      r2 = step8(s_q.cnt2, s_q.second_reload);
      udf2 = r2[8];
      s_d.cnt2 = r2[7:0];
    end
    if (udf2) begin
      s_d.pin0_out = !s_q.pin0_out; // see RL4
    end

    // Third timer with start sync and auto-stop
    case (s_q.c3[1:0])
      SRC3_PWM: tick3 = s_q.pwm && !s_q.pwm_prev; // see RL25
      SRC3_PRESC: tick3 = prescaler_output;
      SRC3_SECOND_TIMER_UNDERFLOW: tick3 = udf2;
      default: tick3 = pin1_rise; // see RL22
    endcase
    run3 = s_q.c3[C3_RUN] && (!third_sync_select_bit || s_q.sync3); // see RL7
    if (run3 && tick3) begin
      r3 = step8(s_q.cnt3, s_q.third_reload);
      udf3 = r3[8];
      s_d.cnt3 = r3[7:0];
    end
    if (!third_sync_select_bit || (udf3 && s_q.c3[C3_AUTOSTOP])) begin
      s_d.sync3 = 1'b0; // see RL8
    end
    if (third_sync_select_bit && ext_irq_pin_one_edge) begin
      s_d.sync3 = 1'b1; // see RL7
    end

    // PWM gate toggled by third underflow; released while third is stopped
    if (!s_q.c6[C6_AUTO_GATE] || !s_q.c3[C3_RUN]) begin
      s_d.gate = 1'b1; // see RL15
    end else if (udf3) begin
      s_d.gate = !s_q.gate; // see RL15
    end

    // Fourth timer and PWM
    tick4 = s_q.c4[C4_SRC] ? (prescaler_output && s_q.pre_div) : main_osc_tick; // see RL26
    // Clearing run only takes effect outside the high phase
    go4 = s_q.c4[C4_RUN] || (s_q.run4 && s_q.phase == PH_HIGH); // see RL16
    s_d.run4 = go4;
    if (go4 && tick4) begin
      next_reload4 = (s_q.c4[C4_PIN_EN] && s_q.phase == PH_LOW) ?
        s_q.pwm_high_reload : s_q.pwm_low_reload; // see RL11
      r4 = step8(s_q.cnt4, next_reload4);
      udf4 = r4[8];
      s_d.cnt4 = r4[7:0];
    end
    if (udf4 && s_q.c4[C4_PIN_EN]) begin
      if (s_q.phase == PH_LOW) begin
        s_d.phase = PH_HIGH;
        s_d.pwm = 1'b1; // see RL12
      end else begin
        s_d.phase = PH_LOW;
        if (s_q.c4[C4_HI_EXT] && s_q.per > 8'h01) begin
          s_d.hold = {1'b0, s_q.per[7:1]}; // see RL13
        end else begin
          s_d.pwm = 1'b0; // see RL12
        end
      end
    end else if (!s_q.c4[C4_PIN_EN]) begin
      s_d.phase = PH_LOW;
      s_d.pwm = 1'b0;
    end
    // Half a source period measured from the last interval between ticks
    if (s_q.hold != 8'h00) begin
      s_d.hold = s_q.hold - 8'h01;
      if (s_q.hold == 8'h01) begin
        s_d.pwm = 1'b0; // see RL13
      end
    end
    if (tick4) begin
      s_d.per = s_q.per_cnt;
      s_d.per_cnt = 8'h01;
    end else if (s_q.per_cnt != 8'hFF) begin
      s_d.per_cnt = s_q.per_cnt + 8'h01;
    end

    // Fifth timer
    case (s_q.c5[1:0])
      2'b00: len_mask = LEN_MASK0; // see RL24
      2'b01: len_mask = LEN_MASK1;
      2'b10: len_mask = LEN_MASK2;
      default: len_mask = LEN_MASK3;
    endcase
    tick5 = s_q.c5[C5_RUN] && sub_rise; // see RL17
    t5b4 = tick5 && (s_q.cnt5[4:0] == 5'h00);
    if (!s_q.c5[C5_RUN]) begin
      s_d.cnt5 = CNT5_RST; // see RL18
    end else if (tick5) begin
      udf5 = (s_q.cnt5 & len_mask) == 16'h0000;
      s_d.cnt5 = s_q.cnt5 - 16'h0001;
    end
    s_d.wake = udf5 && power_down; // see RL19

    // LCD timer
    ticklc = s_q.c6[C6_LC_SRC] ? prescaler_output : t5b4; // see RL27
    if (s_q.c6[C6_LC_RUN] && ticklc) begin
      if (s_q.cntlc == 4'h0) begin
        udflc = 1'b1;
        s_d.cntlc = s_q.lcd_timer_reload; // see RL20
      end else begin
        s_d.cntlc = s_q.cntlc - 4'h1;
      end
    end
    if (udflc) begin
      s_d.lcd_clk = !s_q.lcd_clk; // see RL21
    end

    // Flags: a set in the same cycle as a clear wins, so no underflow is lost
    udf_all = {udf5, udf4, udf3, udf2};
    for (int i = 0; i < 4; i++) begin
      if (udf_all[i]) begin
        s_d.flags[i] = 1'b1; // see RL23
      end else if (flag_clr[i]) begin
        s_d.flags[i] = 1'b0; // see RL23
      end
    end

    // Instructions; direct counter access assumes the timer is stopped
    case (cmd.op)
      OP_LD_SECOND: begin
        s_d.cnt2 = cmd.data;
        s_d.second_reload = cmd.data;
      end
      OP_LD_THIRD_BOTH: begin
        s_d.cnt3 = cmd.data; // see RL5
        s_d.third_reload = cmd.data;
      end
      OP_WR_THIRD_RELOAD: s_d.third_reload = cmd.data; // see RL5
      OP_LD_FOURTH_LOW: begin
        s_d.cnt4 = cmd.data; // see RL9
        s_d.pwm_low_reload = cmd.data;
      end
      OP_WR_HIGH_RELOAD: s_d.pwm_high_reload = cmd.data; // see RL9
      OP_RESTORE_FOURTH: s_d.cnt4 = s_q.pwm_low_reload; // see RL9
      OP_LD_LCD: begin
        s_d.cntlc = cmd.data[3:0]; // see RL20
        s_d.lcd_timer_reload = cmd.data[3:0];
      end
      OP_WR_CTRL2: s_d.c2 = cmd.data[3:0];
      OP_WR_CTRL3: s_d.c3 = cmd.data[3:0];
      OP_WR_CTRL4: s_d.c4 = cmd.data[3:0];
      OP_WR_CTRL5: s_d.c5 = cmd.data[3:0];
      OP_WR_CTRL6: s_d.c6 = cmd.data[3:0];
      default: ;
    endcase

    // Pin levels and enables taken from the next state, so each pin leaves a flop
    // with no extra cycle of delay against the state it reflects
    s_d.pin1_o = s_d.pwm && s_d.gate; // see RL15
    s_d.pin0_oe = s_d.c2[C2_OUT_SEL] && s_d.c6[C6_PIN0_EN]; // see RL4
    s_d.pin1_oe = s_d.c4[C4_PIN_EN] && (s_d.c3[1:0] != SRC3_PIN); // see RL22
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.cnt5 <= CNT5_RST;
      s_q.gate <= 1'b1;
      s_q.phase <= PH_LOW;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs taken straight from the state register
  always_comb begin
    irq_flags = s_q.flags;
    third_count = s_q.cnt3; // see RL5
    fourth_count = s_q.cnt4; // see RL9
    ctrl_read = {s_q.c6, s_q.c5, s_q.c4, s_q.c3, s_q.c2};
    counter_pin_zero_o = s_q.pin0_out;
    counter_pin_zero_oe = s_q.pin0_oe; // see RL4
    counter_pin_one_o = s_q.pin1_o; // see RL15
    counter_pin_one_oe = s_q.pin1_oe; // see RL22
    lcd_clock = s_q.lcd_clk;
    wake_pulse = s_q.wake;
  end

endmodule // mtp_timer_unit

// *** verification/mtp_pin_model.sv ***
`timescale 1ns/1ps
module mtp_pin_model
  import mtp_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic sub_en, // run the sub-clock
  input wire logic pin_drv, // our level on pin one
  input wire logic pin_o, // block level on pin one
  input wire logic pin_oe, // block drives pin one
  output logic subclock_input, // sub-clock pin
  output logic counter_pin_one_in // resolved pin one
);
  logic [1:0] div_q = 2'h0;
  // Slow crystal: four core cycles a period, frozen while disabled
  always @(posedge clk) begin
    if (sub_en) begin
      div_q <= div_q + 2'h1;
    end
  end
  assign subclock_input = div_q[1];
  // The block owns the wire while it drives; otherwise our level shows
  assign counter_pin_one_in = pin_oe ? pin_o : pin_drv;
endmodule // mtp_pin_model

// *** verification/mtp_timer_monitor.sv ***
`timescale 1ns/1ps
module mtp_timer_monitor
  import mtp_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_b, // sync reset
  input wire logic [3:0] flag_clr, // flag clears
  input wire logic power_down, // power-down level
  input wire logic [3:0] irq_flags, // request flags
  input wire logic [19:0] ctrl_read, // control readback
  input wire logic counter_pin_zero_o, // pin zero level
  input wire logic counter_pin_zero_oe, // pin zero drive
  input wire logic counter_pin_one_oe, // pin one drive
  input wire logic lcd_clock, // lcd clock
  input wire logic wake_pulse // wake request
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wake_once;
    wake_pulse ##1 !wake_pulse;
  endsequence
  chk_wake_single: assert property (wake_pulse |-> s_wake_once)
    else $error("wake pulse longer than one cycle");
  chk_wake_cause: assert property (wake_pulse |-> irq_flags[3] && $past(power_down))
    else $error("wake without fifth underflow in power-down");
  // A flag may only drop on a clear request, never by itself
  chk_flag_hold: assert property (!(|($past(irq_flags) & ~irq_flags & ~$past(flag_clr))))
    else $error("request flag dropped without clear");
  chk_third_run: assert property ($rose(irq_flags[1]) |-> $past(ctrl_read[6]))
    else $error("third flag set while third timer stopped");
  chk_pin0_oe: assert property (counter_pin_zero_oe == (ctrl_read[3] && ctrl_read[16]))
    else $error("pin zero drive does not follow its enables");
  chk_pin1_oe: assert property (counter_pin_one_oe == (ctrl_read[11] && ctrl_read[5:4] != 2'h3))
    else $error("pin one drive wrong for its source or enable");
  chk_pin0_moves: assert property ($changed(counter_pin_zero_o) |-> $past(ctrl_read[2]))
    else $error("pin zero moved while second timer stopped");
  chk_lcd_hold: assert property (!$past(ctrl_read[19]) |-> $stable(lcd_clock))
    else $error("lcd clock moved while lcd timer stopped");
endmodule // mtp_timer_monitor

bind mtp_timer_unit mtp_timer_monitor u_mon (.clk(clk), .rst_b(rst_b), .flag_clr(flag_clr),
  .power_down(power_down), .irq_flags(irq_flags), .ctrl_read(ctrl_read),
  .counter_pin_zero_o(counter_pin_zero_o), .counter_pin_zero_oe(counter_pin_zero_oe),
  .counter_pin_one_oe(counter_pin_one_oe), .lcd_clock(lcd_clock), .wake_pulse(wake_pulse));

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import mtp_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  mtp_cmd_t cmd = '0;
  logic [3:0] fc = 4'h0;
  logic [2:0] tk = 3'h0;
  logic sel = 1'b0, pd = 1'b0, sub_en = 1'b0, pin_drv = 1'b0;
  logic sub_in, pin_in, p0_o, p0_oe, p1_o, p1_oe, lcd_clock, wake_pulse;
  logic [3:0] irq_flags;
  logic [7:0] third_count, fourth_count;
  logic [19:0] ctrl_read;
  localparam logic [6:0] PWM_EXP = 7'h4e;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  always #2 clk = ~clk;
  mtp_timer_unit dut (.clk(clk), .rst_b(rst_b), .cmd(cmd), .flag_clr(fc),
    .third_sync_select_bit(sel), .ext_irq_pin_one_edge(tk[2]), .prescaler_output(tk[0]),
    .main_osc_tick(tk[1]), .first_timer_underflow(1'b0), .subclock_input(sub_in),
    .counter_pin_one_in(pin_in), .power_down(pd), .irq_flags(irq_flags),
    .third_count(third_count), .fourth_count(fourth_count), .ctrl_read(ctrl_read),
    .counter_pin_zero_o(p0_o), .counter_pin_zero_oe(p0_oe), .counter_pin_one_o(p1_o),
    .counter_pin_one_oe(p1_oe), .lcd_clock(lcd_clock), .wake_pulse(wake_pulse));
  mtp_pin_model u_pin (.clk(clk), .sub_en(sub_en), .pin_drv(pin_drv), .pin_o(p1_o),
    .pin_oe(p1_oe), .subclock_input(sub_in), .counter_pin_one_in(pin_in));
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Extra edge after the take lets registered outputs settle
  task automatic op(input mtp_op_t o, input logic [7:0] d);
    @(posedge clk) cmd <= '{o, d};
    @(posedge clk) cmd <= '{OP_NONE, 8'h00};
    @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [2:0] v, input logic [3:0] f);
    @(posedge clk) begin tk <= v; fc <= f; end
    @(posedge clk) begin tk <= 3'h0; fc <= 4'h0; end
    @(posedge clk);
    #1;
  endtask
  task automatic test_done;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #300_000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    op(OP_LD_THIRD_BOTH, 8'h02);
    chk(20'(third_count), 20'h2);
    op(OP_WR_CTRL3, 8'h05);
    for (int i = 1; i <= 2; i++) begin
      pulse(3'h1, 4'h0);
      chk(20'(third_count), 20'(2 - i));
    end
    pulse(3'h1, 4'h0);
    chk(20'(third_count), 20'h2);
    chk(20'(irq_flags[1]), 20'h1);
    pulse(3'h0, 4'h2);
    chk(20'(irq_flags[1]), 20'h0);
    op(OP_WR_CTRL3, 8'h00);
    op(OP_WR_THIRD_RELOAD, 8'h05);
    chk(20'(third_count), 20'h2);
    op(OP_WR_CTRL3, 8'h05);
    repeat (3) pulse(3'h1, 4'h0);
    chk(20'(third_count), 20'h5);
    op(OP_WR_CTRL3, 8'h00);
    op(OP_LD_THIRD_BOTH, 8'h01);
    @(posedge clk) sel <= 1'b1;
    op(OP_WR_CTRL3, 8'h0d);
    pulse(3'h1, 4'h0);
    chk(20'(third_count), 20'h1);
    pulse(3'h4, 4'h0);
    pulse(3'h1, 4'h0);
    chk(20'(third_count), 20'h0);
    pulse(3'h1, 4'h0);
    pulse(3'h1, 4'h0);
    chk(20'(third_count), 20'h1);
    @(posedge clk) sel <= 1'b0;
    op(OP_WR_CTRL3, 8'h00);
    op(OP_LD_SECOND, 8'h00);
    op(OP_WR_CTRL6, 8'h01);
    op(OP_WR_CTRL2, 8'h0d);
    chk(20'(p0_oe), 20'h1);
    pulse(3'h1, 4'h0);
    chk(20'(p0_o), 20'h1);
    pulse(3'h1, 4'h0);
    chk(20'(p0_o), 20'h0);
    chk(20'(irq_flags[0]), 20'h1);
    op(OP_WR_CTRL2, 8'h00);
    op(OP_LD_LCD, 8'h01);
    op(OP_WR_CTRL6, 8'h0c);
    for (int i = 1; i <= 4; i++) begin
      pulse(3'h1, 4'h0);
      chk(20'(lcd_clock), 20'((i >> 1) & 1));
    end
    op(OP_WR_CTRL6, 8'h00);
    op(OP_LD_FOURTH_LOW, 8'h01);
    op(OP_WR_HIGH_RELOAD, 8'h02);
    op(OP_WR_CTRL4, 8'h0a);
    for (int i = 0; i < 7; i++) begin
      pulse(3'h2, 4'h0);
      chk(20'(p1_o), 20'(PWM_EXP[i]));
    end
    op(OP_WR_CTRL4, 8'h08);
    repeat (3) pulse(3'h2, 4'h0);
    chk(20'(p1_o), 20'h0);
    pulse(3'h2, 4'h0);
    chk(20'(fourth_count), 20'h1);
    op(OP_LD_FOURTH_LOW, 8'h03);
    chk(20'(fourth_count), 20'h3);
    op(OP_WR_CTRL4, 8'h02);
    pulse(3'h2, 4'h0);
    chk(20'(fourth_count), 20'h2);
    op(OP_WR_CTRL4, 8'h00);
    op(OP_RESTORE_FOURTH, 8'h00);
    chk(20'(fourth_count), 20'h3);
    op(OP_LD_FOURTH_LOW, 8'h00);
    op(OP_WR_HIGH_RELOAD, 8'h01);
    op(OP_WR_CTRL4, 8'h0e);
    repeat (2) pulse(3'h2, 4'h0);
    chk(20'(p1_o), 20'h1);
    @(posedge clk) tk <= 3'h2;
    @(posedge clk) tk <= 3'h0;
    #1;
    chk(20'(p1_o), 20'h1);
    @(posedge clk);
    #1;
    chk(20'(p1_o), 20'h0);
    chk(20'(irq_flags[2]), 20'h1);
    op(OP_WR_HIGH_RELOAD, 8'hff);
    op(OP_WR_CTRL4, 8'h0a);
    pulse(3'h2, 4'h0);
    op(OP_LD_THIRD_BOTH, 8'h00);
    op(OP_WR_CTRL6, 8'h02);
    op(OP_WR_CTRL3, 8'h05);
    for (int i = 0; i < 3; i++) begin
      pulse(3'h1, 4'h0);
      chk(20'(p1_o), 20'(i & 1));
    end
    op(OP_WR_CTRL3, 8'h00);
    chk(20'(p1_o), 20'h1);
    op(OP_WR_CTRL6, 8'h00);
    op(OP_WR_CTRL4, 8'h08);
    op(OP_WR_CTRL3, 8'h03);
    chk(20'(p1_oe), 20'h0);
    op(OP_LD_THIRD_BOTH, 8'h01);
    op(OP_WR_CTRL3, 8'h07);
    @(posedge clk) pin_drv <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(20'(third_count), 20'h0);
    op(OP_WR_CTRL5, 8'h04);
    @(posedge clk) begin pd <= 1'b1; sub_en <= 1'b1; end
    n = 0;
    while (wake_pulse !== 1'b1 && n < 40000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(20'(irq_flags[3]), 20'h1);
    chk(20'(n > 32750 && n < 32800), 20'h1);
    op(OP_WR_CTRL5, 8'h00);
    test_done;
  end
endmodule // tb_top
